// ===== testbench/acp_host_model.sv
// Host side of the serial mode port: frames words, strap levels, pulled-up SDO.
// Assumes tasks are called from the bench just after a falling clock edge.
`timescale 1ns/10ps
`default_nettype none
module acp_host_model (
   output logic      o_cs_b,    // Chip select, active low
   output logic      o_sck,     // Serial clock, still outside frames
   output logic      o_sdi,     // Serial data to device
   input  wire logic i_sdo_out, // Device SDO level
   input  wire logic i_sdo_oe   // Device pulls SDO
);
   logic sdo_wire;
   assign sdo_wire = i_sdo_oe ? i_sdo_out : 1'b1;
   initial begin
      o_cs_b = 1'b1;
      o_sck  = 1'b0;
      o_sdi  = 1'b0;
   end
   task automatic strap(input logic cs, input logic sck, input logic sdi);
      o_cs_b = cs;
      o_sck  = sck;
      o_sdi  = sdi;
   endtask : strap
   // Fewer than 16 rises aborts; more than 16 sends junk the device must ignore
   task automatic xfer(input logic [15:0] w, input int nrise, output logic [7:0] rd);
      rd = 8'h00;
      #1;
      o_cs_b = 1'b0;
      for (int k = 0; k < nrise; k++) begin
         o_sdi = (k < 16) ? w[15 - k] : ~o_sdi;
         #16;
         if (k >= 8 && k < 16) rd = {rd[6:0], sdo_wire};
         o_sck = 1'b1;
         #16;
         o_sck = 1'b0;
      end
      #16;
      o_cs_b = 1'b1;
      o_sdi  = ~o_sdi;
   endtask : xfer
endmodule : acp_host_model
`default_nettype wire

// ===== testbench/tb_top.sv
// Self-checking bench: register traffic, readback, straps, output formatting.
// Assumes acp_port and acp_host_model are compiled before it.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin mismatches++; $display("[FAIL] t=%0t got=%h exp=%h", $time, a, b); end end
module tb_top;
   logic        clk = 1'b0;
   logic        rst_b = 1'b0;
   logic        mode = 1'b0;
   logic        sv = 1'b0;
   logic        ov = 1'b0;
   logic [11:0] cd = 12'h000;
   logic        cs_b, sck, sdi, sdo_out, sdo_oe, of, doe, cinv, duty_cycle_stabilizer_enable, term, hz, odd, scr, sgn;
   logic [11:0] od;
   logic [1:0]  pwr, dly, ofm;
   logic [2:0]  cur, tp;
   logic [2:0]  lastp = 3'h0;
   logic [12:0] ua;
   logic [7:0]  sh [1:4];
   logic [7:0]  rd;
   integer      seed = 86;
   int          mismatches = 0;
   int          num_checks = 0;
   int          cyc = 0;

   acp_port u_acp_port (
      .i_ref_clk(clk), .i_rst_b(rst_b), .i_program_mode_select(mode), .i_cs_b(cs_b),
      .i_sck(sck), .i_sdi(sdi), .o_sdo_out(sdo_out), .o_sdo_oe(sdo_oe),
      .i_sample_valid(sv), .i_conv_data(cd), .i_conv_ovr(ov), .o_out_data(od),
      .o_overrange_flag(of), .o_data_oe(doe), .o_power_state_field(pwr),
      .o_output_clock_invert(cinv), .o_output_clock_delay_field(dly),
      .o_duty_cycle_stabilizer_enable(duty_cycle_stabilizer_enable), .o_lvds_drive_current_field(cur),
      .o_lvds_internal_termination(term), .o_lvds_drive_ua(ua), .o_output_high_z(hz),
      .o_output_format_field(ofm), .o_test_pattern_field(tp),
      .o_odd_bit_invert_enable(odd), .o_lsb_xor_scramble_enable(scr),
      .o_signed_format_select(sgn));
   acp_host_model u_acp_host_model (.o_cs_b(cs_b), .o_sck(sck), .o_sdi(sdi),
      .i_sdo_out(sdo_out), .i_sdo_oe(sdo_oe));

   always #2 clk = ~clk;

   task automatic end_sim();
      $display("checks=%0d mismatches=%0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : end_sim

   // Hang guard, well above the few dozen frames' worth of cycles used
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         mismatches++;
         end_sim();
      end
   end

   function automatic logic [12:0] exp_ua(input logic [7:0] r);
      int u;
      case (r[6:4])
         3'h0: u = 13'hdac;
         3'h1: u = 13'hfa0;
         3'h2: u = 13'h1194;
         3'h4: u = 13'hbb8;
         3'h5: u = 13'h9c4;
         3'h6: u = 13'h834;
         3'h7: u = 13'h6d6;
         default: u = 0;
      endcase
      return 13'(r[3] ? u * 16 / 10 : u);
   endfunction : exp_ua

   function automatic logic [12:0] exp_fmt(input logic [7:0] f, input logic [11:0] d,
                                           input logic o);
      logic [11:0] x;
      x = d;
      if (f[0] && !f[2]) x[11] = ~x[11];
      if (f[1]) x[11:1] = x[11:1] ^ {11{x[0]}};
      if (f[2]) x = x ^ 12'haaa;
      case (f[5:3])
         3'h1: return 13'h0000;
         3'h3: return 13'h1fff;
         default: return {o, x};
      endcase
   endfunction : exp_fmt

   task automatic chk_cfg();
      `CHK(pwr, sh[1][1:0])
      `CHK({cinv, dly, duty_cycle_stabilizer_enable}, sh[2][3:0])
      `CHK({cur, term, hz}, sh[3][6:2])
      `CHK(ofm, sh[3][1:0])
      `CHK(ua, exp_ua(sh[3]))
      `CHK(doe, ~sh[3][2])
      `CHK({tp, odd, scr, sgn}, sh[4][5:0])
   endtask : chk_cfg

   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      u_acp_host_model.xfer({1'b0, a, d}, 16, rd);
      repeat (8) @(negedge clk);
   endtask : wr

   task automatic rdb(input logic [6:0] a, input logic [7:0] e);
      u_acp_host_model.xfer({1'b1, a, 8'($random(seed))}, 16, rd);
      `CHK(rd, e)
      `CHK({sdo_out, sdo_oe}, 2'h0)
      repeat (8) @(negedge clk);
   endtask : rdb

   // Patterns toggle per sample, so only consecutive samples of one code compare
   task automatic samp();
      logic [12:0] prev;
      logic [12:0] p0;
      prev = {of, od};
      sv = 1'b1;
      cd = 12'($random(seed));
      ov = 1'($random(seed));
      @(negedge clk);
      sv = 1'b0;
      repeat (2) @(negedge clk);
      p0 = (sh[4][5:3] == 3'h5) ? 13'h1555 : 13'h0000;
      if (sh[4][5:3] == 3'h5 || sh[4][5:3] == 3'h7) begin
         `CHK({of, od} === p0 || {of, od} === ~p0, 1'b1)
         if (lastp == sh[4][5:3]) `CHK({of, od}, ~prev)
      end else begin
         `CHK({of, od}, exp_fmt(sh[4], cd, ov))
      end
      lastp = sh[4][5:3];
   endtask : samp

   initial begin
      logic [6:0] a;
      logic [7:0] d;
      repeat (6) @(negedge clk);
      rst_b = 1'b1;
      repeat (8) @(negedge clk);
      `CHK(doe, 1'b1)
      wr(7'h00, 8'h80);
      for (int k = 1; k <= 4; k++) sh[k] = 8'h00;
      chk_cfg();
      for (int i = 0; i < 24; i++) begin
         a = 7'(1 + $unsigned($random(seed)) % 6);
         d = 8'($random(seed));
         if (a == 7'h02) d[0] = |d[2:1];
         wr(a, d);
         if (a <= 7'h04) sh[a[2:0]] = d;
         rdb(a, (a <= 7'h04) ? sh[a[2:0]] : 8'h00);
         chk_cfg();
         samp();
      end
      for (int c = 0; c < 8; c++) begin
         d = {2'h0, 3'(c), 3'($random(seed))};
         wr(7'h04, d);
         sh[4] = d;
         repeat (3) samp();
      end
      u_acp_host_model.xfer({1'b0, 7'h01, 8'h03}, 10, rd);
      repeat (8) @(negedge clk);
      u_acp_host_model.xfer({1'b0, 7'h02, 8'h0f}, 20, rd);
      sh[2] = 8'h0f;
      repeat (8) @(negedge clk);
      chk_cfg();
      mode = 1'b1;
      for (int k = 0; k < 8; k++) begin
         u_acp_host_model.strap(k[2], k[1], k[0]);
         repeat (8) @(negedge clk);
         `CHK(duty_cycle_stabilizer_enable, k[2])
         `CHK({ofm, cur, term}, {1'b0, k[1], 4'h0})
         if (k[1]) `CHK(ua, 13'hdac)
         `CHK(pwr, {2{k[0]}})
      end
      u_acp_host_model.strap(1'b1, 1'b0, 1'b0);
      repeat (4) @(negedge clk);
      mode = 1'b0;
      repeat (8) @(negedge clk);
      chk_cfg();
      wr(7'h00, 8'hff);
      for (int k = 1; k <= 4; k++) sh[k] = 8'h00;
      chk_cfg();
      for (int k = 0; k <= 4; k++) rdb(7'(k), 8'h00);
      end_sim();
   end
endmodule : tb_top
`default_nettype wire

// ===== verilog/acp_pkg.sv
// Constants of the converter mode configuration port.
// Shared by the port logic; no other assumptions.
package acp_pkg;
   // Register addresses
   localparam logic [6:0] ADDR_RST = 7'h00;
   localparam logic [6:0] ADDR_PWR = 7'h01;
   localparam logic [6:0] ADDR_TIM = 7'h02;
   localparam logic [6:0] ADDR_DRV = 7'h03;
   localparam logic [6:0] ADDR_FMT = 7'h04;
   localparam logic [7:0] REG_RESET_VAL = 8'h00;
   // Field positions
   localparam int RST_BIT    = 7;
   localparam int PWR_LSB    = 0;
   localparam int OUTPUT_CLOCK_INVERT_BIT = 3;
   localparam int DLY_LSB    = 1;
   localparam int DCS_BIT    = 0;
   localparam int CUR_LSB    = 4;
   localparam int TERM_BIT   = 3;
   localparam int HIZ_BIT    = 2;
   localparam int OFMT_LSB   = 0;
   localparam int TP_LSB     = 3;
   localparam int ABP_BIT    = 2;
   localparam int LSB_XOR_SCRAMBLE_ENABLE_BIT   = 1;
   localparam int TWOS_BIT   = 0;
   // Serial word framing
   localparam logic [4:0] WORD_BITS = 5'h10;
   localparam logic [4:0] HDR_BITS  = 5'h08;
   // Codes
   localparam logic [1:0] PWR_NORMAL = 2'h0;
   localparam logic [1:0] PWR_SLEEP  = 2'h3;
   localparam logic [1:0] OFMT_CMOS  = 2'h0;
   localparam logic [1:0] OFMT_LVDS  = 2'h1;
   localparam logic [2:0] TP_ZEROS   = 3'h1;
   localparam logic [2:0] TP_ONES    = 3'h3;
   localparam logic [2:0] TP_CHECK   = 3'h5;
   localparam logic [2:0] TP_ALT     = 3'h7;
   localparam logic [12:0] CHECK_PAT = 13'h1555;
   localparam logic [11:0] ODD_BITS  = 12'haaa;
endpackage : acp_pkg

// ===== verilog/acp_port.sv
// Mode configuration port: pin straps or serial word registers,
// plus the output formatter that the format register steers.
// Assumes pins are asynchronous to i_ref_clk and sck is slow (>=4 clocks/half).
`timescale 1ns/10ps
`default_nettype none
// How it works
// - Mode pin high: pins are static strap levels
// - Strap chip-select sets duty stabilizer
// - Strap sck picks CMOS or LVDS 3.5mA
// - Strap data-in high means sleep
// - Mode pin low: pins form serial port
// - Chip-select frames; first 16 sck edges count
// - Word: rw, 7 address, 8 data, MSB first
// - Write flag low stores data byte
// - Read drives register out, no update
// - Serial out only pulls low
// - Reset bit clears all mode registers
// - Power field: normal, nap, sleep
// - Timing: clock invert and phase delay
// - Drive current field selects LVDS current
// - Termination on scales current by 1.6
// - High-z bit disables digital outputs
// - Format field: CMOS, DDR LVDS, DDR CMOS
// - Test pattern field selects fixed patterns
// - Odd invert, scramble, signed; invert forces offset
// - Test pattern overrides all formatting
// - Scrambler XORs LSB into upper bits
// - Odd-bit inversion flips odd data bits
module acp_port (
   input  wire logic        i_ref_clk,        // 250 MHz clock
   input  wire logic        i_rst_b,          // Async reset, active low
   input  wire logic        i_program_mode_select, // High: pin straps
   input  wire logic        i_cs_b,           // Chip select pin, active low
   input  wire logic        i_sck,            // Serial clock pin
   input  wire logic        i_sdi,            // Serial data in pin
   output logic             o_sdo_out,        // Serial out level, always low
   output logic             o_sdo_oe,         // Serial out pull-down enable
   input  wire logic        i_sample_valid,   // Converter sample strobe
   input  wire logic [11:0] i_conv_data,      // Raw offset-binary sample
   input  wire logic        i_conv_ovr,       // Raw overrange
   output logic [11:0]      o_out_data,       // Formatted data
   output logic             o_overrange_flag, // Formatted overrange
   output logic             o_data_oe,        // Digital outputs enabled
   output logic [1:0]       o_power_state_field,       // Power mode
   output logic             o_output_clock_invert,     // Clock invert
   output logic [1:0]       o_output_clock_delay_field, // Phase delay
   output logic             o_duty_cycle_stabilizer_enable, // Stabilizer
   output logic [2:0]       o_lvds_drive_current_field, // Current code
   output logic             o_lvds_internal_termination, // Termination
   output logic [12:0]      o_lvds_drive_ua,  // Effective current, uA
   output logic             o_output_high_z,  // Outputs high-z
   output logic [1:0]       o_output_format_field, // Output format
   output logic [2:0]       o_test_pattern_field,  // Test pattern
   output logic             o_odd_bit_invert_enable, // Odd inversion
   output logic             o_lsb_xor_scramble_enable, // Scrambler
   output logic             o_signed_format_select // Two's complement
);
   logic              rst_meta;
   logic              rst_s;
   logic [3:0]        pin_meta;
   logic [3:0]        pin_s;
   logic              sck_prev;
   logic              ser_mode;
   logic              cs_act;
   logic              sck_rise;
   logic [4:0]        bit_cnt;
   logic [15:0]       shreg;
   logic              rd_flag;
   logic [7:0]        rd_data;
   logic              wr_go;
   logic [6:0]        wr_addr;
   logic [7:0]        wr_data;
   logic [3:0][7:0]   mode_reg;
   logic              alt_phase;
   logic [11:0]       next_data;

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         rst_meta <= 1'b0;
         rst_s    <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_s    <= rst_meta;
      end
   end

   // Order: mode select, chip select, sck, sdi
   always_ff @(posedge i_ref_clk or negedge rst_s) begin
      if (!rst_s) begin
         pin_meta <= 4'h4;
         pin_s    <= 4'h4;
         sck_prev <= 1'b0;
      end else begin
         pin_meta <= {i_program_mode_select, i_cs_b, i_sck, i_sdi};
         pin_s    <= pin_meta;
         sck_prev <= pin_s[1];
      end
   end

   assign ser_mode = ~pin_s[3];
   assign cs_act   = ser_mode & ~pin_s[2];
   assign sck_rise = pin_s[1] & ~sck_prev;

   // Edges past the sixteenth are ignored
   always_ff @(posedge i_ref_clk or negedge rst_s) begin
      if (!rst_s) begin
         bit_cnt <= 5'h00;
         shreg   <= 16'h0000;
      end else if (!cs_act) begin
         bit_cnt <= 5'h00;
      end else if (sck_rise && bit_cnt < acp_pkg::WORD_BITS) begin
         bit_cnt <= bit_cnt + 5'h01;
         shreg   <= {shreg[14:0], pin_s[0]};
      end
   end
   // Data byte complete and written when the sixteenth bit arrives
   assign wr_go   = cs_act & sck_rise & (bit_cnt == acp_pkg::WORD_BITS - 5'h01)
                    & ~shreg[14];
   assign wr_addr = shreg[13:7];
   assign wr_data = {shreg[6:0], pin_s[0]};

   always_ff @(posedge i_ref_clk or negedge rst_s) begin
      if (!rst_s) begin
         rd_flag <= 1'b0;
         rd_data <= 8'h00;
      end else if (!cs_act) begin
         rd_flag <= 1'b0;
      end else if (sck_rise && bit_cnt == acp_pkg::HDR_BITS - 5'h01) begin
         rd_flag <= shreg[6];
         // Reset register is write only and unmapped reads give zero
         if ({shreg[5:0], pin_s[0]} >= acp_pkg::ADDR_PWR &&
             {shreg[5:0], pin_s[0]} <= acp_pkg::ADDR_FMT)
            rd_data <= mode_reg[2'({shreg[5:0], pin_s[0]} - 7'h01)];
         else
            rd_data <= 8'h00;
      end
   end

   // Pull low only for zero bits; host pull-up makes the ones
   always_ff @(posedge i_ref_clk or negedge rst_s) begin
      if (!rst_s) begin
         o_sdo_oe <= 1'b0;
      end else begin
         o_sdo_oe <= cs_act & rd_flag & bit_cnt[3] & ~bit_cnt[4]
                     & ~rd_data[~bit_cnt[2:0]];
      end
   end
   assign o_sdo_out = 1'b0;

   for (genvar i = 0; i < 4; i++) begin : g_reg
      always_ff @(posedge i_ref_clk or negedge rst_s) begin
         if (!rst_s) begin
            mode_reg[i] <= acp_pkg::REG_RESET_VAL;
         end else if (wr_go && wr_addr == acp_pkg::ADDR_RST &&
                      wr_data[acp_pkg::RST_BIT]) begin
            mode_reg[i] <= acp_pkg::REG_RESET_VAL;
         end else if (wr_go && wr_addr == 7'(i + 1)) begin
            mode_reg[i] <= wr_data;
         end
      end
   end

   function automatic logic [12:0] drive_ua(input logic [2:0] c,
                                            input logic t);
      logic [12:0] b;
      b = 13'h0000;
      unique case (c)
         3'h0: b = 13'd3500;
         3'h1: b = 13'd4000;
         3'h2: b = 13'd4500;
         3'h3: b = 13'd0;
         3'h4: b = 13'd3000;
         3'h5: b = 13'd2500;
         3'h6: b = 13'd2100;
         3'h7: b = 13'd1750;
      endcase
      // Termination scales by 8/5, exact for every code
      return t ? 13'((16'(b) * 16'd8) / 16'd5) : b;
   endfunction : drive_ua

   // Strap mode fixes a subset; the rest stays at defaults
   always_ff @(posedge i_ref_clk or negedge rst_s) begin
      if (!rst_s) begin
         o_power_state_field            <= 2'h0;
         o_output_clock_invert          <= 1'b0;
         o_output_clock_delay_field     <= 2'h0;
         o_duty_cycle_stabilizer_enable <= 1'b0;
         o_lvds_drive_current_field     <= 3'h0;
         o_lvds_internal_termination    <= 1'b0;
         o_lvds_drive_ua                <= 13'h0000;
         o_output_high_z                <= 1'b0;
         o_output_format_field          <= 2'h0;
         o_test_pattern_field           <= 3'h0;
         o_odd_bit_invert_enable        <= 1'b0;
         o_lsb_xor_scramble_enable      <= 1'b0;
         o_signed_format_select         <= 1'b0;
         // Registers reset to 00h, so outputs enabled and never both low with high-z
         o_data_oe                      <= 1'b1;
      end else if (pin_s[3]) begin
         o_duty_cycle_stabilizer_enable <= pin_s[2];
         o_output_format_field <= pin_s[1] ? acp_pkg::OFMT_LVDS
                                           : acp_pkg::OFMT_CMOS;
         o_power_state_field   <= pin_s[0] ? acp_pkg::PWR_SLEEP
                                           : acp_pkg::PWR_NORMAL;
         o_output_clock_invert          <= 1'b0;
         o_output_clock_delay_field     <= 2'h0;
         o_lvds_drive_current_field     <= 3'h0;
         o_lvds_internal_termination    <= 1'b0;
         o_lvds_drive_ua                <= drive_ua(3'h0, 1'b0);
         o_output_high_z                <= 1'b0;
         o_test_pattern_field           <= 3'h0;
         o_odd_bit_invert_enable        <= 1'b0;
         o_lsb_xor_scramble_enable      <= 1'b0;
         o_signed_format_select         <= 1'b0;
         o_data_oe                      <= 1'b1;
      end else begin
         o_power_state_field        <= mode_reg[0][acp_pkg::PWR_LSB +: 2];
         o_output_clock_invert      <= mode_reg[1][acp_pkg::OUTPUT_CLOCK_INVERT_BIT];
         o_output_clock_delay_field <= mode_reg[1][acp_pkg::DLY_LSB +: 2];
         o_duty_cycle_stabilizer_enable <= mode_reg[1][acp_pkg::DCS_BIT];
         o_lvds_drive_current_field <= mode_reg[2][acp_pkg::CUR_LSB +: 3];
         o_lvds_internal_termination <= mode_reg[2][acp_pkg::TERM_BIT];
         o_lvds_drive_ua <= drive_ua(mode_reg[2][acp_pkg::CUR_LSB +: 3],
                                     mode_reg[2][acp_pkg::TERM_BIT]);
         o_output_high_z            <= mode_reg[2][acp_pkg::HIZ_BIT];
         o_data_oe                  <= ~mode_reg[2][acp_pkg::HIZ_BIT];
         o_output_format_field      <= mode_reg[2][acp_pkg::OFMT_LSB +: 2];
         o_test_pattern_field       <= mode_reg[3][acp_pkg::TP_LSB +: 3];
         o_odd_bit_invert_enable    <= mode_reg[3][acp_pkg::ABP_BIT];
         o_lsb_xor_scramble_enable  <= mode_reg[3][acp_pkg::LSB_XOR_SCRAMBLE_ENABLE_BIT];
         o_signed_format_select     <= mode_reg[3][acp_pkg::TWOS_BIT];
      end
   end

   // Formatting order: sign, scramble, odd inversion
   always_comb begin
      next_data = i_conv_data;
      if (o_signed_format_select && !o_odd_bit_invert_enable)
         next_data[11] = ~next_data[11];
      if (o_lsb_xor_scramble_enable)
         next_data[11:1] = next_data[11:1] ^ {11{next_data[0]}};
      if (o_odd_bit_invert_enable)
         next_data = next_data ^ acp_pkg::ODD_BITS;
   end

   always_ff @(posedge i_ref_clk or negedge rst_s) begin
      if (!rst_s) begin
         alt_phase        <= 1'b0;
         o_out_data       <= 12'h000;
         o_overrange_flag <= 1'b0;
      end else if (i_sample_valid) begin
         alt_phase <= ~alt_phase;
         // Unused pattern codes fall back to normal data
         unique case (o_test_pattern_field)
            acp_pkg::TP_ZEROS: {o_overrange_flag, o_out_data} <= 13'h0000;
            acp_pkg::TP_ONES:  {o_overrange_flag, o_out_data} <= 13'h1fff;
            acp_pkg::TP_CHECK: {o_overrange_flag, o_out_data} <=
               alt_phase ? ~acp_pkg::CHECK_PAT : acp_pkg::CHECK_PAT;
            acp_pkg::TP_ALT:   {o_overrange_flag, o_out_data} <=
               {13{alt_phase}};
            default: begin
               o_out_data       <= next_data;
               o_overrange_flag <= i_conv_ovr;
            end
         endcase
      end
   end

   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!rst_s);

   property p_strap_dcs;
      pin_s[3] |=> o_duty_cycle_stabilizer_enable == $past(pin_s[2]);
   endproperty
   a_strap_dcs: assert property (p_strap_dcs)
      else $error("strap stabilizer mismatch");
   property p_strap_fmt;
      pin_s[3] && pin_s[1] |=> o_output_format_field == 2'h1 &&
                                o_lvds_drive_ua == 13'd3500;
   endproperty
   a_strap_fmt: assert property (p_strap_fmt)
      else $error("strap lvds mode mismatch");
   property p_strap_pwr;
      pin_s[3] && pin_s[0] |=> o_power_state_field == 2'h3;
   endproperty
   a_strap_pwr: assert property (p_strap_pwr)
      else $error("strap sleep mismatch");
   property p_cnt_cap;
      bit_cnt <= 5'h10;
   endproperty
   a_cnt_cap: assert property (p_cnt_cap)
      else $error("bit count past sixteen");
   property p_wr_tim;
      wr_go && wr_addr == 7'h02 |=> mode_reg[1] == $past(wr_data);
   endproperty
   a_wr_tim: assert property (p_wr_tim)
      else $error("timing register write lost");
   property p_rd_keep;
      rd_flag |=> $stable(mode_reg);
   endproperty
   a_rd_keep: assert property (p_rd_keep)
      else $error("register changed during read");
   property p_soft_rst;
      wr_go && wr_addr == 7'h00 && wr_data[7] |=> mode_reg == '0;
   endproperty
   a_soft_rst: assert property (p_soft_rst)
      else $error("software reset did not clear");
   property p_hiz;
      o_data_oe != o_output_high_z;
   endproperty
   a_hiz: assert property (p_hiz)
      else $error("output enable disagrees with high-z");
   property p_tp_zero;
      i_sample_valid && o_test_pattern_field == 3'h1
         |=> o_out_data == 12'h000 && !o_overrange_flag;
   endproperty
   a_tp_zero: assert property (p_tp_zero)
      else $error("zero pattern not forced");
endmodule : acp_port
`default_nettype wire
